// *** logic/fsw_pkg.sv ***
// Package for the floating-point status word block: field layout,
// operation classes and the packed records passed across its ports.
// Assumes a single processor clock domain.
`default_nettype none
package fsw_pkg;

    localparam int FSW_WIDTH       = 16;
    localparam int FSW_FLAG_LO     = 0;
    localparam int FSW_FLAG_HI     = 5;
    localparam int FSW_STACK_FAULT = 6;
    localparam int FSW_SUMMARY     = 7;
    localparam int FSW_COND_ZERO   = 8;
    localparam int FSW_COND_ONE    = 9;
    localparam int FSW_COND_TWO    = 10;
    localparam int FSW_HEAD_LO     = 11;
    localparam int FSW_HEAD_HI     = 13;
    localparam int FSW_COND_THREE  = 14;
    localparam int FSW_MIRROR      = 15;
    localparam int FSW_NUM_FLAGS   = 6;

    localparam logic [2:0] FSW_HEAD_RESET  = 3'h0;
    localparam logic [3:0] FSW_COND_RESET  = 4'h0;
    localparam logic [5:0] FSW_FLAG_RESET  = 6'h00;
    localparam logic [5:0] FSW_MASK_RESET  = 6'h3F;

    // Operation classes as seen by the status word
    typedef enum logic [3:0] {
        FSW_OP_NONE,
        FSW_OP_COMPARE,
        FSW_OP_COMPARE_FLAGS,
        FSW_OP_CLASSIFY,
        FSW_OP_REMAINDER,
        FSW_OP_TRIG,
        FSW_OP_ARITH,
        FSW_OP_LOAD,
        FSW_OP_PUSH_LOAD,
        FSW_OP_HEAD_INC,
        FSW_OP_HEAD_DEC,
        FSW_OP_ENV_LOAD,
        FSW_OP_NO_COND,
        FSW_OP_EXC_CLEAR,
        FSW_OP_INIT,
        FSW_OP_STATE_SAVE
    } fsw_op_e;

    // One retiring operation and its outcome
    typedef struct packed {
        logic       valid;
        fsw_op_e    op;
        logic [3:0] cond;      // c3,c2,c1,c0 result from the datapath
        logic [5:0] events;    // exceptions detected by this operation
        logic       stackFault;
        logic       overflowDir; // 1 overflow, 0 underflow
        logic       roundUp;
        logic       popHead;   // store-and-pop increments the head
        logic [15:0] image;    // memory image for environment loads
    } fsw_op_s;

    typedef struct packed {
        logic        valid;
        logic        toAccum;  // status store to the accumulator
        logic [15:0] word;
    } fsw_store_s;

endpackage
`default_nettype wire

// *** logic/fsw_status_word.sv ***
// Floating-point status word: stack head, condition bits, sticky
// exception flags, stack fault, unmasked-fault summary and mirror.
// Assumes one retiring operation per cycle from the execution logic.
`timescale 1ns/100ps
`default_nettype none

// Function
// - Keep a 16-bit status word updated after each floating-point operation.
// - Whole word storable by store, env-store, save; also to accumulator.
// - Bits 13..11 hold the stack head pointer, range 0 to 7.
// - Compares write c0,c3 result, c2 unordered, c1 zero unless stack fault.
// - On stack fault c1 is 1 for overflow, 0 for underflow.
// - With inexact set, c1 shows whether final rounding went upward.
// - Classify puts sign in c1 and class in the other bits.
// - Remainder sets c2 if incomplete, else quotient bits in c0,c3,c1.
// - Trig ops set c2 when out of range; c1 undefined then.
// - Arithmetic ops leave c0,c2,c3 undefined; c1 is roundup or fault.
// - Load-type ops leave three bits undefined; c1 zero unless fault.
// - Environment load loads condition bits from memory.
// - After no-condition ops bits are undefined; nobody relies on them.
// - Bits 5..0 are six sticky exception flags since last clear.
// - Summary bit 7 set while any unmasked flag is set.
// - Masked exceptions still set their flag but not the summary.
// - Flags stay set until clear, init, save, or overwritten by an environment load.
// - Bit 15 always mirrors the summary bit.
// - Bit 6 stack fault set on overflow/underflow, not cleared by invalid.
// - Stack fault stays set until init, clear, save, or overwritten by an environment load.
// - Push load decrements head first, wrapping 0 to 7.
// - Control word bits 5..0 mask the six exception flags.
module fsw_status_word
    import fsw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire fsw_op_s     opIn,
    input  wire logic [5:0]  exceptionMask,
    input  wire logic        storeReq,
    input  wire logic        storeToAccum,
    output fsw_store_s       storeOut,
    output logic [15:0]      statusWord,
    output logic             handlerReq
);

    logic [2:0] stackHead;
    logic [3:0] cond;        // {c3,c2,c1,c0}
    logic [5:0] flags;
    logic       stackFault;
    logic       summary;

    logic [2:0] next_stackHead;
    logic [3:0] next_cond;
    logic [5:0] next_flags;
    logic       next_stackFault;
    logic       next_summary;

    // Operation decode
    wire opValid   = opIn.valid;
    wire isEnvLoad = opValid && (opIn.op == FSW_OP_ENV_LOAD);
    wire isClear   = opValid && (opIn.op == FSW_OP_EXC_CLEAR
                             || opIn.op == FSW_OP_INIT
                             || opIn.op == FSW_OP_STATE_SAVE);
    wire isInit    = opValid && (opIn.op == FSW_OP_INIT
                             || opIn.op == FSW_OP_STATE_SAVE);
    wire opFault   = opValid && opIn.stackFault;
    wire [5:0] opEvents = opValid ? opIn.events : 6'h00;
    wire inexactNow = opEvents[FSW_FLAG_HI];

    // Fault or round-up driven c1
    wire faultOrRound = opFault ? opIn.overflowDir
                      : (inexactNow & opIn.roundUp);
    wire faultOrZero  = opFault ? opIn.overflowDir : 1'b0;

    // Condition bits per operation class
    always_comb begin
        next_cond = cond;
        if (opValid) begin
            unique case (opIn.op)
                FSW_OP_COMPARE: begin
                    next_cond = {opIn.cond[3], opIn.cond[2], faultOrZero,
                                 opIn.cond[0]};
                end
                FSW_OP_COMPARE_FLAGS: begin
                    // Result goes elsewhere; only c1 carries the fault
                    next_cond = {1'b0, 1'b0, faultOrZero, 1'b0};
                end
                FSW_OP_CLASSIFY: begin
                    next_cond = opIn.cond;
                end
                FSW_OP_REMAINDER: begin
                    if (opIn.cond[2]) begin
                        next_cond = {1'b0, 1'b1, faultOrZero, 1'b0};
                    end else begin
                        next_cond = {opIn.cond[3], 1'b0,
                                     opFault ? opIn.overflowDir
                                             : opIn.cond[1],
                                     opIn.cond[0]};
                    end
                end
                FSW_OP_TRIG: begin
                    // Undefined c1 driven low when out of range
                    next_cond = {1'b0, opIn.cond[2],
                                 opIn.cond[2] ? 1'b0 : faultOrRound,
                                 1'b0};
                end
                FSW_OP_ARITH: begin
                    next_cond = {1'b0, 1'b0, faultOrRound, 1'b0};
                end
                FSW_OP_LOAD, FSW_OP_PUSH_LOAD,
                FSW_OP_HEAD_INC, FSW_OP_HEAD_DEC: begin
                    next_cond = {1'b0, 1'b0, faultOrZero, 1'b0};
                end
                FSW_OP_ENV_LOAD: begin
                    next_cond = {opIn.image[FSW_COND_THREE],
                                 opIn.image[FSW_COND_TWO],
                                 opIn.image[FSW_COND_ONE],
                                 opIn.image[FSW_COND_ZERO]};
                end
                FSW_OP_NO_COND, FSW_OP_EXC_CLEAR: begin
                    next_cond = FSW_COND_RESET;
                end
                FSW_OP_INIT, FSW_OP_STATE_SAVE: begin
                    next_cond = FSW_COND_RESET;
                end
                FSW_OP_NONE: begin
                    next_cond = cond;
                end
            endcase
        end
    end

    // Stack head pointer; 3-bit arithmetic wraps 0 to 7
    always_comb begin
        next_stackHead = stackHead;
        if (isInit) begin
            next_stackHead = FSW_HEAD_RESET;
        end else if (isEnvLoad) begin
            next_stackHead = opIn.image[FSW_HEAD_HI:FSW_HEAD_LO];
        end else if (opValid && (opIn.op == FSW_OP_PUSH_LOAD
                              || opIn.op == FSW_OP_HEAD_DEC)) begin
            next_stackHead = stackHead - 3'h1;
        end else if (opValid && (opIn.op == FSW_OP_HEAD_INC
                              || opIn.popHead)) begin
            next_stackHead = stackHead + 3'h1;
        end
    end

    // Sticky flags: new events win over a clear in the same cycle
    always_comb begin
        if (isEnvLoad) begin
            next_flags      = opIn.image[FSW_FLAG_HI:FSW_FLAG_LO];
            next_stackFault = opIn.image[FSW_STACK_FAULT];
        end else begin
            next_flags      = (isClear ? FSW_FLAG_RESET : flags)
                            | opEvents;
            // Invalid without a stack fault leaves this bit alone
            next_stackFault = (isClear ? 1'b0 : stackFault)
                            | opFault;
        end
    end

    // Masked exceptions still flag but never raise the summary
    wire [5:0] unmasked = next_flags & ~exceptionMask;
    assign next_summary = |unmasked;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stackHead  <= FSW_HEAD_RESET;
            cond       <= FSW_COND_RESET;
            flags      <= FSW_FLAG_RESET;
            stackFault <= 1'b0;
            summary    <= 1'b0;
        end else begin
            stackHead  <= next_stackHead;
            cond       <= next_cond;
            flags      <= next_flags;
            stackFault <= next_stackFault;
            summary    <= next_summary;
        end
    end

    // Assembled word, mirror bit follows the summary
    wire [15:0] wordNow = {summary, cond[3], stackHead, cond[2], cond[1],
                           cond[0], summary, stackFault, flags};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            statusWord <= 16'h0000;
            handlerReq <= 1'b0;
            storeOut   <= '0;
        end else begin
            statusWord <= {next_summary, next_cond[3], next_stackHead,
                           next_cond[2:0], next_summary, next_stackFault,
                           next_flags};
            handlerReq <= next_summary;
            storeOut.valid   <= storeReq;
            storeOut.toAccum <= storeReq & storeToAccum;
            storeOut.word    <= wordNow;
        end
    end

endmodule
`default_nettype wire

// *** bench/fsw_status_word_asserts.sv ***
// Checker for the status word block: field relations over time.
// Bound to fsw_status_word; sees only its ports, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module fsw_status_word_asserts
    import fsw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire fsw_op_s     opIn,
    input  wire logic [5:0]  exceptionMask,
    input  wire logic        storeReq,
    input  wire logic        storeToAccum,
    input  wire fsw_store_s  storeOut,
    input  wire logic [15:0] statusWord,
    input  wire logic        handlerReq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Ops that clear or overwrite the sticky flags
    wire clrOp = opIn.valid && (opIn.op inside {FSW_OP_EXC_CLEAR,
        FSW_OP_INIT, FSW_OP_STATE_SAVE, FSW_OP_ENV_LOAD});
    wire initOp = opIn.valid && opIn.op == FSW_OP_INIT
        && opIn.events == 6'h00 && !opIn.stackFault;
    wire pushOp = opIn.valid && opIn.op == FSW_OP_PUSH_LOAD;
    property p_mirror;
        handlerReq == statusWord[7] && statusWord[15] == statusWord[7];
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("mirror or handler off summary");
    property p_summary;
        statusWord[7] == |(statusWord[5:0] & ~$past(exceptionMask));
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary wrong for mask");
    property p_sticky;
        opIn.valid && !clrOp |=> statusWord[5:0] ==
            ($past(statusWord[5:0]) | $past(opIn.events));
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flags not accumulated");
    property p_hold;
        !opIn.valid |=> $stable(statusWord[14:8]) && $stable(statusWord[6:0]);
    endproperty
    a_hold: assert property (p_hold)
        else $error("word changed without op");
    property p_store;
        storeReq |=> storeOut.valid && storeOut.word == $past(statusWord)
            && storeOut.toAccum == $past(storeToAccum);
    endproperty
    a_store: assert property (p_store)
        else $error("store result wrong");
    property p_push;
        pushOp |=> statusWord[13:11] == $past(statusWord[13:11]) - 3'h1;
    endproperty
    a_push: assert property (p_push)
        else $error("head not decremented");
    property p_fault;
        opIn.valid && opIn.stackFault && (opIn.op inside {FSW_OP_LOAD,
            FSW_OP_ARITH, FSW_OP_COMPARE}) |=> statusWord[6]
            && statusWord[9] == $past(opIn.overflowDir);
    endproperty
    a_fault: assert property (p_fault)
        else $error("stack fault report wrong");
    property p_init;
        initOp |=> statusWord == 16'h0000;
    endproperty
    a_init: assert property (p_init)
        else $error("init left bits set");
    c_push: cover property (pushOp);
    c_store: cover property (storeReq ##1 storeOut.valid);
    c_handler: cover property ($rose(handlerReq));
endmodule
`default_nettype wire

// *** bench/fsw_exec_model.sv ***
// Execution-side model: retires operations and requests stores.
// Drives the status word block just after falling clock edges.
`timescale 1ns/100ps
`default_nettype none
module fsw_exec_model
    import fsw_pkg::*;
(
    input  wire logic clk,
    output fsw_op_s   opIn,
    output logic      storeReq,
    output logic      storeToAccum
);
    initial begin
        opIn = '0;
        storeReq = 1'b0;
        storeToAccum = 1'b0;
    end
    // Never reads condition bits back after ops that spoil them
    task automatic issue(input fsw_op_e op, input logic [3:0] cond,
        input logic [5:0] ev, input logic [2:0] flt,
        input logic [15:0] img = 16'h0000);
        @(negedge clk);
        opIn = '{1'b1, op, cond, ev, flt[2], flt[1], flt[0], 1'b0, img};
        @(negedge clk);
        // Released fields scrambled, not held
        opIn = {1'b0, ~opIn[$bits(fsw_op_s)-2:0]};
    endtask
    task automatic store(input logic acc);
        @(negedge clk);
        storeReq = 1'b1;
        storeToAccum = acc;
        @(negedge clk);
        storeReq = 1'b0;
        storeToAccum = ~acc;
    endtask
endmodule
`default_nettype wire

// *** bench/fpu_status_word_logic_tb_top.sv ***
// Top testbench for the status word block with its execution model.
// Assumes ops land at the next rising edge and show just after that same edge.
`timescale 1ns/100ps
`default_nettype none
module fpu_status_word_logic_tb_top
    import fsw_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [5:0]  mask = 6'h3F;
    fsw_op_s     opIn;
    logic        storeReq;
    logic        storeToAccum;
    fsw_store_s  storeOut;
    logic [15:0] statusWord;
    logic        handlerReq;
    int          bad_count = 0;
    int          cmp_count = 0;
    fsw_op_e     opList[4] = '{FSW_OP_COMPARE, FSW_OP_CLASSIFY,
                               FSW_OP_REMAINDER, FSW_OP_TRIG};
    always #5 clk = ~clk;
    fsw_exec_model u_exec(.clk(clk), .opIn(opIn), .storeReq(storeReq),
        .storeToAccum(storeToAccum));
    fsw_status_word DUT(.clk(clk), .rst_n(rst_n), .opIn(opIn),
        .exceptionMask(mask), .storeReq(storeReq),
        .storeToAccum(storeToAccum), .storeOut(storeOut),
        .statusWord(statusWord), .handlerReq(handlerReq));
    task automatic chk(input string nm, input logic [15:0] exp,
        input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("BAD %s exp %h got %h", nm, exp, got);
            bad_count++;
        end
    endtask
    task automatic final_report;
        if (bad_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic t_push; // Head wraps 0 to 7, then counts down
        for (int k = 1; k <= 9; k++) begin
            u_exec.issue(FSW_OP_PUSH_LOAD, 4'h0, 6'h00, 3'h0);
            chk("head", 16'({3'(8 - k), 3'h0}), 16'(statusWord[13:8]));
        end
    endtask
    task automatic t_cond; // Every nibble through four op classes
        logic [3:0]  c;
        logic [3:0]  e;
        logic [15:0] m;
        for (int i = 0; i < 64; i++) begin
            c = 4'(i);
            e = (i < 16) ? (c & 4'hD) : c;
            m = (i < 32) ? 16'h4700 : (i < 48 && !c[2]) ? 16'h4700 : 16'h0400;
            u_exec.issue(opList[i / 16], c, 6'h00, 3'h0);
            chk("cond", {1'b0, e[3], 3'h0, e[2:0], 8'h00} & m, statusWord & m);
        end
    endtask
    task automatic t_exc; // Masking, faults, stores, clears, loads
        u_exec.issue(FSW_OP_ARITH, 4'h0, 6'h20, 3'h1);
        chk("inexact", 16'h0220, statusWord & 16'h82FF);
        mask = 6'h1F;
        @(negedge clk);
        chk("summary", 16'h8080, statusWord & 16'h8080);
        chk("handler", 16'h0001, 16'(handlerReq));
        u_exec.issue(FSW_OP_LOAD, 4'h0, 6'h01, 3'h6);
        chk("fault", 16'h0261, statusWord & 16'h027F);
        u_exec.issue(FSW_OP_ARITH, 4'h0, 6'h01, 3'h0);
        chk("keep", 16'h0061, statusWord & 16'h027F);
        for (int a = 1; a >= 0; a--) begin
            u_exec.store(1'(a));
            chk("store", 16'hB8E1, storeOut.word);
            chk("target", 16'(2 + a), 16'({storeOut.valid, storeOut.toAccum}));
        end
        u_exec.issue(FSW_OP_EXC_CLEAR, 4'h0, 6'h00, 3'h0);
        chk("clear", 16'h3800, statusWord & 16'hB8FF);
        u_exec.issue(FSW_OP_ENV_LOAD, 4'h0, 6'h00, 3'h0, 16'h4F25);
        chk("envload", 16'h4F25, statusWord & 16'h7F7F);
        u_exec.issue(FSW_OP_COMPARE_FLAGS, 4'hF, 6'h00, 3'h6);
        chk("cmpflags", 16'h0200, statusWord & 16'h4700);
        u_exec.issue(FSW_OP_INIT, 4'h0, 6'h00, 3'h0);
        chk("init", 16'h0000, statusWord);
        chk("idle", 16'h0000, 16'(handlerReq));
    endtask
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        chk("reset", 16'h0000, statusWord);
        t_push();
        t_cond();
        t_exc();
        final_report();
    end
    initial begin
        #100000;
        bad_count++;
        final_report();
    end
endmodule
bind fsw_status_word fsw_status_word_asserts u_chk(
    .clk(clk), .rst_n(rst_n), .opIn(opIn), .exceptionMask(exceptionMask),
    .storeReq(storeReq), .storeToAccum(storeToAccum),
    .storeOut(storeOut), .statusWord(statusWord), .handlerReq(handlerReq));
`default_nettype wire
